// File: hw/aotr_consts.vh
// Register offsets, mode codes, reset values and decode constants for the accel register bank
`ifndef AOTR_CONSTS_VH
`define AOTR_CONSTS_VH
`define AOTR_ADDR_Y_LO        8'h2A
`define AOTR_ADDR_Y_HI        8'h2B
`define AOTR_ADDR_Z_LO        8'h2C
`define AOTR_ADDR_Z_HI        8'h2D
`define AOTR_ADDR_QCTRL       8'h2E
`define AOTR_ADDR_QSTAT       8'h2F
`define AOTR_ADDR_XTAP        8'h30
`define AOTR_ADDR_YTAP        8'h31
`define AOTR_QCTRL_RST        8'h00
`define AOTR_XTAP_RST         8'h00
`define AOTR_YTAP_RST         8'h00
`define AOTR_MODE_BYPASS      3'h0
`define AOTR_MODE_FIFO        3'h1
`define AOTR_MODE_CONT_FIFO   3'h3
`define AOTR_MODE_BYP_CONT    3'h4
`define AOTR_MODE_CONT        3'h6
`define AOTR_QUEUE_DEPTH      32
`define AOTR_STAGE_DEPTH      8
`define AOTR_ORIENT_T0        5'h06
`define AOTR_ORIENT_T1        5'h0B
`define AOTR_ORIENT_T2        5'h10
`define AOTR_ORIENT_T3        5'h15
`define AOTR_LP1_MASK         8'hF3
`define AOTR_LO_MASK          8'hFC
`define AOTR_PRIO_XYZ         6'h06
`define AOTR_PRIO_YXZ         6'h12
`define AOTR_PRIO_XZY         6'h09
`define AOTR_PRIO_ZYX         6'h24
`define AOTR_PRIO_YZX         6'h18
`define AOTR_PRIO_ZXY         6'h21
`endif

// File: hw/aotr_stage_fifo.v
// Parameterised valid/ready FIFO that stages incoming samples ahead of the sample queue
`timescale 1ns/1ns
`default_nettype none
module aotr_stage_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  // Pointers wrap explicitly so DEPTH need not be a power of two
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      if (push & ~pop)
        count_ff <= count_ff + 1'b1;
      else if (pop & ~push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule // aotr_stage_fifo
`default_nettype wire

// File: hw/aotr_tap_decode.v
// Decoder for orientation threshold and tap axis ordering fields
`timescale 1ns/1ns
`default_nettype none
`include "aotr_consts.vh"
module aotr_tap_decode (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Configuration fields
  input  wire [1:0] orientation_angle_threshold,
  input  wire [2:0] tap_axis_ordering,
  // Decoded values
  output reg  [4:0] orient_lsb,
  output reg  [5:0] axis_rank
);
  // axis_rank: [5:4] max, [3:2] mid, [1:0] min; 0=X 1=Y 2=Z
  reg [4:0] nxt_orient;
  reg [5:0] nxt_rank;

  always @*
  begin
    case (orientation_angle_threshold)
      2'h0:    nxt_orient = `AOTR_ORIENT_T0;
      2'h1:    nxt_orient = `AOTR_ORIENT_T1;
      2'h2:    nxt_orient = `AOTR_ORIENT_T2;
      default: nxt_orient = `AOTR_ORIENT_T3;
    endcase
    case (tap_axis_ordering)
      3'h0:    nxt_rank = `AOTR_PRIO_XYZ;
      3'h1:    nxt_rank = `AOTR_PRIO_YXZ;
      3'h2:    nxt_rank = `AOTR_PRIO_XZY;
      3'h3:    nxt_rank = `AOTR_PRIO_ZYX;
      3'h4:    nxt_rank = `AOTR_PRIO_XYZ;
      3'h5:    nxt_rank = `AOTR_PRIO_YZX;
      3'h6:    nxt_rank = `AOTR_PRIO_ZXY;
      default: nxt_rank = `AOTR_PRIO_ZYX;
    endcase
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      orient_lsb <= `AOTR_ORIENT_T0;
      axis_rank  <= `AOTR_PRIO_XYZ;
    end
    else
    begin
      orient_lsb <= nxt_orient;
      axis_rank  <= nxt_rank;
    end
  end
endmodule // aotr_tap_decode
`default_nettype wire

// File: hw/aotr_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "aotr_consts.vh"
module aotr_regs #(
  parameter QDEPTH = `AOTR_QUEUE_DEPTH,
  parameter SDEPTH = `AOTR_STAGE_DEPTH
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Register port from the serial host interface
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Sample source
  input  wire        smp_valid,
  output wire        smp_ready,
  input  wire [15:0] smp_y,
  input  wire [15:0] smp_z,
  input  wire        odr_tick,
  input  wire        queue_trigger,
  input  wire        low_power_1,
  // Configuration out to detection engines
  output wire        planar_orientation_only_enable,
  output wire [4:0]  orient_lsb,
  output wire [4:0]  x_axis_tap_level,
  output wire [4:0]  y_axis_tap_level,
  output wire [5:0]  axis_rank
);
  localparam CW = 6;
  localparam [CW-1:0] QFULL = QDEPTH[CW-1:0];

  reg  [7:0]    qctrl_ff;
  reg  [7:0]    xtap_ff;
  reg  [7:0]    ytap_ff;
  reg  [15:0]   y_out_ff;
  reg  [15:0]   z_out_ff;
  reg  [31:0]   qmem [0:QDEPTH-1];
  reg  [4:0]    qwr_ff;
  reg  [4:0]    qrd_ff;
  reg  [CW-1:0] qcnt_ff;
  reg           ovr_ff;
  reg           trig_ff;
  reg  [2:0]    prev_mode_ff;
  reg  [7:0]    nxt_rdata;
  wire [2:0]    queue_operating_select;
  wire [4:0]    queue_level_threshold;
  wire          stg_valid;
  wire [31:0]   stg_data;
  wire          take;
  wire          store;
  wire          overwrite;
  wire          pop;
  wire          queue_threshold_reached;
  wire          queue_overrun_flag;
  wire [31:0]   head;
  reg  [1:0]    eff_mode;

  localparam [1:0] EM_BYPASS = 2'h0;
  localparam [1:0] EM_FIFO   = 2'h1;
  localparam [1:0] EM_CONT   = 2'h2;

  // Low byte masking shared by both axes
  function [7:0] lo_byte;
    input [7:0] b;
    input       lp1;
    begin
      lo_byte = b & `AOTR_LO_MASK & (lp1 ? `AOTR_LP1_MASK : 8'hFF);
    end
  endfunction

  assign queue_operating_select         = qctrl_ff[7:5];
  assign queue_level_threshold          = qctrl_ff[4:0];
  assign planar_orientation_only_enable = xtap_ff[7];
  assign x_axis_tap_level               = xtap_ff[4:0];
  assign y_axis_tap_level               = ytap_ff[4:0];

  aotr_stage_fifo #(
    .WIDTH (32),
    .DEPTH (SDEPTH),
    .AW    (3)
  ) u_stage (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   ({smp_y, smp_z}),
    .out_valid (stg_valid),
    .out_ready (odr_tick),
    .out_data  (stg_data)
  );

  aotr_tap_decode u_dec (
    .ref_clk                     (ref_clk),
    .rst                         (rst),
    .orientation_angle_threshold (xtap_ff[6:5]),
    .tap_axis_ordering           (ytap_ff[7:5]),
    .orient_lsb                  (orient_lsb),
    .axis_rank                   (axis_rank)
  );

  // Resolve the programmed mode plus sampled trigger into one of three behaviours
  always @*
  begin
    case (queue_operating_select)
      `AOTR_MODE_FIFO:      eff_mode = EM_FIFO;
      `AOTR_MODE_CONT:      eff_mode = EM_CONT;
      `AOTR_MODE_CONT_FIFO: eff_mode = trig_ff ? EM_CONT : EM_FIFO;
      `AOTR_MODE_BYP_CONT:  eff_mode = trig_ff ? EM_BYPASS : EM_FIFO;
      default:              eff_mode = EM_BYPASS;
    endcase
  end

  // Staged samples are drained one per output-data-rate tick
  assign take      = stg_valid & odr_tick;
  assign store     = take & (eff_mode != EM_BYPASS) & ((qcnt_ff != QFULL) | (eff_mode == EM_CONT));
  assign overwrite = store & (qcnt_ff == QFULL);
  assign head      = qmem[qrd_ff];
  // Reading the Z high byte consumes one queued sample
  assign pop       = reg_rd & (reg_addr == `AOTR_ADDR_Z_HI) & (qcnt_ff != {CW{1'b0}}) & ~overwrite;
  assign queue_threshold_reached = (qcnt_ff >= {1'b0, queue_level_threshold});
  assign queue_overrun_flag      = ovr_ff & (qcnt_ff == QFULL);

  always @(posedge ref_clk)
  begin
    if (store)
      qmem[qwr_ff] <= stg_data;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      qwr_ff       <= 5'h00;
      qrd_ff       <= 5'h00;
      qcnt_ff      <= {CW{1'b0}};
      ovr_ff       <= 1'b0;
      trig_ff      <= 1'b0;
      prev_mode_ff <= `AOTR_MODE_BYPASS;
      y_out_ff     <= 16'h0000;
      z_out_ff     <= 16'h0000;
    end
    else
    begin
      prev_mode_ff <= queue_operating_select;
      if (odr_tick)
        trig_ff <= queue_trigger;
      // Bypass empties the queue; changing the mode restarts it
      if ((eff_mode == EM_BYPASS) || (prev_mode_ff != queue_operating_select))
      begin
        qwr_ff  <= 5'h00;
        qrd_ff  <= 5'h00;
        qcnt_ff <= {CW{1'b0}};
        ovr_ff  <= 1'b0;
      end
      else
      begin
        if (store)
          qwr_ff <= qwr_ff + 5'h01;
        if (overwrite | pop)
          qrd_ff <= qrd_ff + 5'h01;
        if (store & ~overwrite & ~pop)
          qcnt_ff <= qcnt_ff + 6'h01;
        else if (pop & ~store)
          qcnt_ff <= qcnt_ff - 6'h01;
        // Overwrite sets ahead of the clear that a read causes
        if (overwrite)
          ovr_ff <= 1'b1;
        else if (pop)
          ovr_ff <= 1'b0;
      end
      // Output words follow the queue head when buffering, else live data
      if (eff_mode == EM_BYPASS)
      begin
        if (take)
        begin
          y_out_ff <= stg_data[31:16];
          z_out_ff <= stg_data[15:0];
        end
      end
      else if (qcnt_ff != {CW{1'b0}})
      begin
        y_out_ff <= head[31:16];
        z_out_ff <= head[15:0];
      end
    end
  end

  // Host writes reach only the three writable registers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      qctrl_ff <= `AOTR_QCTRL_RST;
      xtap_ff  <= `AOTR_XTAP_RST;
      ytap_ff  <= `AOTR_YTAP_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `AOTR_ADDR_QCTRL: qctrl_ff <= reg_wdata;
        `AOTR_ADDR_XTAP:  xtap_ff  <= reg_wdata;
        `AOTR_ADDR_YTAP:  ytap_ff  <= reg_wdata;
        default:          qctrl_ff <= qctrl_ff;
      endcase
    end
  end

  always @*
  begin
    case (reg_addr)
      `AOTR_ADDR_Y_LO:  nxt_rdata = lo_byte(y_out_ff[7:0], low_power_1);
      `AOTR_ADDR_Y_HI:  nxt_rdata = y_out_ff[15:8];
      `AOTR_ADDR_Z_LO:  nxt_rdata = lo_byte(z_out_ff[7:0], low_power_1);
      `AOTR_ADDR_Z_HI:  nxt_rdata = z_out_ff[15:8];
      `AOTR_ADDR_QCTRL: nxt_rdata = qctrl_ff;
      `AOTR_ADDR_QSTAT: nxt_rdata = {queue_threshold_reached, queue_overrun_flag, qcnt_ff};
      `AOTR_ADDR_XTAP:  nxt_rdata = xtap_ff;
      `AOTR_ADDR_YTAP:  nxt_rdata = ytap_ff;
      default:          nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= nxt_rdata;
  end
endmodule // aotr_regs
`default_nettype wire

// File: testbench/aotr_regs_chk.sv
// Port-level assertions for the accel register bank
`timescale 1ns/1ns
`default_nettype none
module aotr_regs_chk #(
  parameter QDEPTH = 32
) (
  // Watched ports
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       low_power_1,
  input wire logic       planar_orientation_only_enable,
  input wire logic [4:0] orient_lsb,
  input wire logic [4:0] x_axis_tap_level,
  input wire logic [4:0] y_axis_tap_level,
  input wire logic [5:0] axis_rank
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence wr_x;
    reg_wr && reg_addr == 8'h30;
  endsequence
  sequence rd_lo;
    reg_rd && (reg_addr == 8'h2A || reg_addr == 8'h2C);
  endsequence
  // Expected ranking per priority code: [5:4] max, [3:2] mid, [1:0] min; 0=X 1=Y 2=Z
  function automatic logic [5:0] rank_of(input logic [2:0] p);
    case (p)
      3'h0, 3'h4: rank_of = 6'h06;
      3'h1:       rank_of = 6'h12;
      3'h2:       rank_of = 6'h09;
      3'h3, 3'h7: rank_of = 6'h24;
      3'h5:       rank_of = 6'h18;
      default:    rank_of = 6'h21;
    endcase
  endfunction
  low_zero_a: assert property (rd_lo |=> reg_rdata[1:0] == 2'h0)
    else $error("low byte bits 1:0 set");
  lp_mask_a: assert property (rd_lo and low_power_1 |=> reg_rdata[3:2] == 2'h0)
    else $error("low byte bits 3:2 set in low power");
  count_max_a: assert property (reg_rd && reg_addr == 8'h2F |=> reg_rdata[5:0] <= QDEPTH)
    else $error("unread count above depth");
  xtap_load_a: assert property (wr_x |=> x_axis_tap_level == $past(reg_wdata[4:0]))
    else $error("x tap level not loaded");
  ytap_load_a: assert property (reg_wr && reg_addr == 8'h31 |=>
    y_axis_tap_level == $past(reg_wdata[4:0])) else $error("y tap level not loaded");
  planar_load_a: assert property (wr_x |=>
    planar_orientation_only_enable == $past(reg_wdata[7])) else $error("planar bit wrong");
  orient_dec_a: assert property (wr_x |-> ##2
    orient_lsb == 5'h06 + 5'h05 * $past(reg_wdata[6:5], 2)) else $error("orient decode");
  rank_set_a: assert property (axis_rank inside {6'h06, 6'h12, 6'h09, 6'h24, 6'h18, 6'h21})
    else $error("illegal axis rank");
  rank_dec_a: assert property (reg_wr && reg_addr == 8'h31 |-> ##2
    axis_rank == rank_of($past(reg_wdata[7:5], 2))) else $error("axis rank decode wrong");
endmodule // aotr_regs_chk
bind aotr_regs aotr_regs_chk #(.QDEPTH(QDEPTH)) u_aotr_regs_chk (.ref_clk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .low_power_1, .planar_orientation_only_enable,
  .orient_lsb, .x_axis_tap_level, .y_axis_tap_level, .axis_rank);
`default_nettype wire

// File: testbench/aotr_src_model.sv
// Sample source that offers one sample per request and holds it until taken
`timescale 1ns/1ns
`default_nettype none
module aotr_src_model (
  // Clock, reset, request
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        req,
  // Sample handshake
  output var logic         smp_valid,
  input  wire logic        smp_ready,
  output var logic  [15:0] smp_y,
  output var logic  [15:0] smp_z
);
  logic [7:0] cnt_ff;
  logic       vld_ff;
  // Idle data is inverted so a late capture shows as a wrong value
  assign smp_valid = vld_ff;
  assign smp_y     = vld_ff ? {cnt_ff, 8'hBF} : ~{cnt_ff, 8'hBF};
  assign smp_z     = vld_ff ? {~cnt_ff, 8'h4E} : {cnt_ff, 8'hB1};
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cnt_ff <= 8'h00;
      vld_ff <= 1'h0;
    end
    else if (vld_ff && smp_ready)
    begin
      cnt_ff <= cnt_ff + 8'h01;
      vld_ff <= 1'h0;
    end
    else if (req)
      vld_ff <= 1'h1;
endmodule // aotr_src_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the accel register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        odr_tick = 1'h0;
  logic        queue_trigger = 1'h0;
  logic        low_power_1 = 1'h0;
  logic        req = 1'h0;
  logic [8:0]  rsv = 9'h0AF;
  wire  [7:0]  reg_rdata;
  wire         smp_valid;
  wire         smp_ready;
  wire  [15:0] smp_y;
  wire  [15:0] smp_z;
  int          fail_count = 0;
  int          n_checks = 0;
  int          i;
  int          k;
  aotr_regs u_aotr_regs (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .smp_valid, .smp_ready, .smp_y, .smp_z, .odr_tick, .queue_trigger, .low_power_1,
    .planar_orientation_only_enable(), .orient_lsb(), .x_axis_tap_level(),
    .y_axis_tap_level(), .axis_rank());
  aotr_src_model u_aotr_src_model (.ref_clk, .rst, .req, .smp_valid, .smp_ready, .smp_y, .smp_z);
  initial
    forever #10 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    chk8($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic push;
    @(posedge ref_clk);
    req <= 1'h1;
    @(posedge ref_clk);
    req <= 1'h0;
    @(negedge ref_clk);
    for (k = 0; k < 20 && smp_valid; k++)
      @(negedge ref_clk);
    if (smp_valid !== 1'h0)
    begin
      fail_count++;
      end_sim;
    end
  endtask
  task automatic tick;
    @(posedge ref_clk);
    odr_tick <= 1'h1;
    @(posedge ref_clk);
    odr_tick <= 1'h0;
  endtask
  task automatic store(input int n);
    repeat (n)
    begin
      push;
      tick;
    end
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    rd(8'h2E, 8'h00);
    rd(8'h2F, 8'h80);
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    done("reset");
    wr(8'h2E, 8'h1F);
    rd(8'h2E, 8'h1F);
    wr(8'h30, 8'hEA);
    rd(8'h30, 8'hEA);
    wr(8'h31, 8'hD5);
    rd(8'h31, 8'hD5);
    wr(8'h40, 8'h12);
    rd(8'h40, 8'h00);
    done("config");
    store(1);
    rd(8'h2A, 8'hBC);
    rd(8'h2B, 8'h00);
    @(posedge ref_clk);
    low_power_1 <= 1'h1;
    rd(8'h2A, 8'hB0);
    @(posedge ref_clk);
    low_power_1 <= 1'h0;
    wr(8'h2C, 8'h00);
    rd(8'h2C, 8'h4C);
    rd(8'h2D, 8'hFF);
    rd(8'h2F, 8'h00);
    repeat (8) push;
    chk8("smp_ready", 8'h00, {7'h00, smp_ready});
    repeat (8) tick;
    done("bypass");
    wr(8'h2E, 8'h24);
    store(3);
    rd(8'h2F, 8'h03);
    store(30);
    rd(8'h2F, 8'hA0);
    rd(8'h2B, 8'h09);
    rd(8'h2D, 8'hF6);
    rd(8'h2F, 8'h9F);
    wr(8'h2F, 8'h00);
    rd(8'h2F, 8'h9F);
    done("fifo");
    wr(8'h2E, 8'hC4);
    store(33);
    rd(8'h2F, 8'hE0);
    rd(8'h2B, 8'h2B);
    done("stream");
    for (i = 0; i < 3; i++)
    begin
      wr(8'h2E, {rsv[i*3+:3], 5'h00});
      store(2);
      rd(8'h2F, 8'h80);
    end
    done("reserved");
    @(posedge ref_clk);
    queue_trigger <= 1'h1;
    tick;
    wr(8'h2E, 8'h60);
    store(33);
    rd(8'h2F, 8'hE0);
    wr(8'h2E, 8'h82);
    store(2);
    rd(8'h2F, 8'h00);
    @(posedge ref_clk);
    queue_trigger <= 1'h0;
    tick;
    store(3);
    rd(8'h2F, 8'h83);
    done("trigger");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
